//--- src/vpas_pkg.sv
package vpas_pkg;
   // ----------------------------------------
   // Amplitude arithmetic
   // ----------------------------------------
   localparam int          AMP_W        = 10;
   localparam logic [9:0]  AMP_MAX      = 10'h3ff;
   localparam int          CS_DIV_SHIFT = 5;             // Divide by 32
   localparam logic [19:0] GRAD_NUMER   = 20'h00100;     // 256
   localparam logic [7:0]  SINE_PEAK    = 8'hf8;         // 248 of 256
   localparam logic [19:0] STEP_MAX     = 20'hfffff;
   localparam int          STEP_W       = 20;
   // ----------------------------------------
   // Chopper timing in clock cycles
   // ----------------------------------------
   localparam logic [10:0] PER_F0       = 11'h200;       // 1024/2
   localparam logic [10:0] PER_F1       = 11'h156;       // 683/2
   localparam logic [10:0] PER_F2       = 11'h100;       // 512/2
   localparam logic [10:0] PER_F3       = 11'h0cd;       // 410/2
   localparam logic [5:0]  BLANK_T0     = 6'h10;
   localparam logic [5:0]  BLANK_T1     = 6'h18;         // 24 cycles
   localparam logic [5:0]  BLANK_T2     = 6'h24;
   localparam logic [5:0]  BLANK_T3     = 6'h36;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [9:0]  AMP_RST      = 10'h000;
   localparam logic [7:0]  TUNE_RST     = 8'h00;
endpackage

//--- src/vpas_divider.sv
module vpas_divider
   import vpas_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [15:0] dividend,
   input  wire logic [19:0] divisor,
   output logic      [9:0]  quotient,
   output logic             done
);
   // ----------------------------------------
   // Restoring serial divider, one bit a cycle
   // ----------------------------------------
   logic [4:0]  bitCnt_r;
   logic [35:0] rem_r;
   logic [15:0] quot_r;
   logic [20:0] trial;

   // Trial subtraction of the shifted remainder
   assign trial = {1'b0, rem_r[34:15]} - {1'b0, divisor};

   // Restart every 17 cycles on latest operands
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bitCnt_r <= 5'h00;
         rem_r    <= 36'h000000000;
         quot_r   <= 16'h0000;
         quotient <= 10'h000;
         done     <= 1'b0;
      end else if (bitCnt_r == 5'h00) begin
         rem_r    <= {20'h00000, dividend};
         bitCnt_r <= 5'h10;
         done     <= 1'b0;
      end else begin
         bitCnt_r <= bitCnt_r - 5'h01;
         if (!trial[20] && divisor != 20'h00000) begin
            rem_r  <= {trial[19:0], rem_r[14:0], 1'b0};
            quot_r <= {quot_r[14:0], 1'b1};
         end else begin
            rem_r  <= {rem_r[34:0], 1'b0};
            quot_r <= {quot_r[14:0], 1'b0};
         end
         if (bitCnt_r == 5'h01) begin
            done     <= 1'b1;
            quotient <= (quot_r[14:9] != 6'h00) ? AMP_MAX : {quot_r[8:0], 1'b0};
         end
      end
   end
endmodule

//--- src/vpas_scaler.sv
module vpas_scaler
   import vpas_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       autoScaleEn,
   input  wire logic       slowDecayMeasureEn,
   input  wire logic       freewheelEn,
   input  wire logic       standstill,
   input  wire logic [1:0] blankTimeSel,
   input  wire logic [1:0] chopperFreqSel,
   input  wire logic [7:0] amplitudeOffset,
   input  wire logic [7:0] amplitudeGradient,
   input  wire logic [4:0] runCurrent,
   input  wire logic [4:0] holdCurrent,
   input  wire logic [4:0] loadReducedCurrent,
   input  wire logic       loadReduceEn,
   input  wire logic       stepPulse,
   input  wire logic       currentBelowTarget,
   output logic      [9:0] totalAmplitude,
   output logic      [9:0] pwmDuty,
   output logic            chopOn,
   output logic            measureSample,
   output logic      [7:0] tunedOffset,
   output logic      [7:0] tunedGradient,
   output logic      [19:0] stepInterval,
   output logic      [4:0] actualCurrentScale
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] stepSync_r;
   logic [1:0] curSync_r;
   logic       stepPrev_r;
   logic       stepEdge;
   logic       curBelow;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stepSync_r <= 2'h0;
         curSync_r  <= 2'h0;
         stepPrev_r <= 1'b0;
      end else begin
         stepSync_r <= {stepSync_r[0], stepPulse};
         curSync_r  <= {curSync_r[0], currentBelowTarget};
         stepPrev_r <= stepSync_r[1];
      end
   end
   assign stepEdge = stepSync_r[1] & ~stepPrev_r;
   assign curBelow = curSync_r[1];

   // ----------------------------------------
   // Step interval measurement
   // ----------------------------------------
   logic [19:0] stepCnt_r;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stepCnt_r    <= 20'h00000;
         stepInterval <= STEP_MAX;
      end else if (stepEdge) begin
         stepCnt_r    <= 20'h00001;
         stepInterval <= stepCnt_r;
      end else if (stepCnt_r != STEP_MAX) begin
         stepCnt_r <= stepCnt_r + 20'h00001;
      end else begin
         stepInterval <= STEP_MAX;
      end
   end

   // ----------------------------------------
   // Current scale selection
   // ----------------------------------------
   logic [4:0] csNxt;
   assign csNxt = loadReduceEn ? loadReducedCurrent
                : (standstill ? holdCurrent : runCurrent);
   always_ff @(posedge clock) begin
      if (!rst_n) actualCurrentScale <= 5'h00;
      else        actualCurrentScale <= csNxt;
   end

   // ----------------------------------------
   // Chopper period and blanking
   // ----------------------------------------
   function automatic logic [10:0] periodOf(input logic [1:0] sel);
      case (sel)
         2'h0:    periodOf = PER_F0;
         2'h1:    periodOf = PER_F1;
         2'h2:    periodOf = PER_F2;
         default: periodOf = PER_F3;
      endcase
   endfunction
   function automatic logic [5:0] blankOf(input logic [1:0] sel);
      case (sel)
         2'h0:    blankOf = BLANK_T0;
         2'h1:    blankOf = BLANK_T1;
         2'h2:    blankOf = BLANK_T2;
         default: blankOf = BLANK_T3;
      endcase
   endfunction

   logic [10:0] perCnt_r;
   logic        periodEnd;
   logic [10:0] onLen;
   logic [10:0] onLen_r;
   logic [17:0] dutyProd;
   logic        inOn;
   logic        pastBlank;
   logic        inBlankOn;
   logic [10:0] blankLen;

   assign periodEnd = (perCnt_r >= periodOf(chopperFreqSel) - 11'h001);
   // Duty = amplitude*248/256 share of the period, 10-bit full scale
   assign dutyProd  = {8'h00, totalAmplitude} * {10'h000, SINE_PEAK};
   // Next on length, 21-bit product so it cannot wrap
   assign onLen     = 11'(({11'h000, dutyProd[17:8]} * {10'h000, periodOf(chopperFreqSel)}) >> 10);
   assign inOn      = perCnt_r < onLen_r;
   assign blankLen  = {5'h00, blankOf(blankTimeSel)};
   assign pastBlank = perCnt_r >= blankLen;
   assign inBlankOn = inOn & pastBlank;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         perCnt_r      <= 11'h000;
         onLen_r       <= 11'h000;
         chopOn        <= 1'b0;
         pwmDuty       <= AMP_RST;
         measureSample <= 1'b0;
      end else begin
         perCnt_r <= periodEnd ? 11'h000 : perCnt_r + 11'h001;
         // On length latched once a period, so no on phase starts mid-period
         onLen_r  <= periodEnd ? onLen : onLen_r;
         chopOn   <= inOn;
         pwmDuty  <= dutyProd[17:8];
         // On phase after blanking, or slow decay when enabled
         measureSample <= inBlankOn
                        | (slowDecayMeasureEn & ~inOn & pastBlank);
      end
   end

   // ----------------------------------------
   // Velocity term through serial divider
   // ----------------------------------------
   logic [9:0] velQuot;
   logic       velDone;
   logic [9:0] velTerm_r;
   logic [7:0] gradSel;
   logic [7:0] ofsSel;

   // Tuned values in automatic mode, programmed ones otherwise
   assign gradSel = autoScaleEn ? tunedGradient : amplitudeGradient;
   assign ofsSel  = autoScaleEn ? tunedOffset   : amplitudeOffset;

   vpas_divider uDiv (
      .clock    (clock),
      .rst_n    (rst_n),
      .dividend ({gradSel, 8'h00}),  // gradient*256
      .divisor  (stepInterval),
      .quotient (velQuot),
      .done     (velDone)
   );

   always_ff @(posedge clock) begin
      if (!rst_n)                      velTerm_r <= 10'h000;
      else if (stepInterval == STEP_MAX) velTerm_r <= 10'h000;
      else if (velDone)                velTerm_r <= velQuot;
   end

   // ----------------------------------------
   // Amplitude sum and regulator
   // ----------------------------------------
   logic [13:0] ofsProd;
   logic [11:0] ffSum;
   logic [9:0]  ffAmp;
   logic [9:0]  regAmp_r;

   assign ofsProd = {6'h00, ofsSel} * {8'h00, ({1'b0, actualCurrentScale} + 6'h01)};
   assign ffSum   = {3'h0, ofsProd[13:CS_DIV_SHIFT]} + {2'h0, velTerm_r};
   assign ffAmp   = (ffSum > {2'h0, AMP_MAX}) ? AMP_MAX : ffSum[9:0];

   // One-LSB step at each period end that falls in a measurement sample, saturating
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         regAmp_r      <= AMP_RST;
         tunedOffset   <= TUNE_RST;
         tunedGradient <= TUNE_RST;
      end else if (autoScaleEn && measureSample && periodEnd) begin
         if (curBelow && regAmp_r != AMP_MAX) regAmp_r <= regAmp_r + 10'h001;
         else if (!curBelow && regAmp_r != 10'h000) regAmp_r <= regAmp_r - 10'h001;
         if (standstill) tunedOffset <= regAmp_r[9:2];
         else if (velTerm_r != 10'h000 && regAmp_r > {ffSum[9:0]})
            tunedGradient <= tunedGradient + 8'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n)                            totalAmplitude <= AMP_RST;
      else if (freewheelEn && csNxt == 5'h00) totalAmplitude <= AMP_RST;
      else if (!autoScaleEn)                 totalAmplitude <= ffAmp;
      else                                   totalAmplitude <= regAmp_r;
   end
endmodule

//--- tb/vpas_scaler_asserts.sv
// ----------------------------------------
// Amplitude scaler port checks
// ----------------------------------------
module vpas_scaler_asserts
   import vpas_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        autoScaleEn,
   input wire logic        slowDecayMeasureEn,
   input wire logic        freewheelEn,
   input wire logic        standstill,
   input wire logic        loadReduceEn,
   input wire logic        stepPulse,
   input wire logic [1:0]  blankTimeSel,
   input wire logic [7:0]  amplitudeOffset,
   input wire logic [4:0]  runCurrent,
   input wire logic [9:0]  totalAmplitude,
   input wire logic [9:0]  pwmDuty,
   input wire logic        chopOn,
   input wire logic        measureSample,
   input wire logic [19:0] stepInterval,
   input wire logic [4:0]  actualCurrentScale
);
   timeunit 1ns;
   timeprecision 1ns;
   // Expected duty and offset term
   wire logic [17:0] dutyExp = ({8'h00, totalAmplitude} * {10'h000, SINE_PEAK}) >> 8;
   wire logic [12:0] offTerm = ({5'h00, amplitudeOffset} * ({8'h00, actualCurrentScale} + 13'h1)) >> 5;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Chopper start and quiet feed-forward spans
   sequence s_chop_start;
      $rose(chopOn) && blankTimeSel == 2'h1 && !slowDecayMeasureEn;
   endsequence
   sequence s_ff_quiet;
      (!autoScaleEn && !freewheelEn && stepInterval == STEP_MAX && $stable(amplitudeOffset)
       && $stable(actualCurrentScale)) [*8];
   endsequence
   a_reset_clears: assert property ($rose(rst_n) |-> totalAmplitude == AMP_RST
      && stepInterval == STEP_MAX && !chopOn) else $error("outputs not cleared by reset");
   a_duty_scaled: assert property ($stable(totalAmplitude) [*2] |-> pwmDuty == dutyExp[9:0])
      else $error("duty does not follow amplitude");
   a_onphase_sample: assert property (measureSample && !$past(slowDecayMeasureEn) |-> chopOn)
      else $error("sample outside on phase");
   a_blank_hold: assert property (s_chop_start |-> !measureSample [*8])
      else $error("sample inside blanking");
   a_freewheel_zero: assert property ((freewheelEn && actualCurrentScale == 5'h00) [*3]
      |-> totalAmplitude == 10'h000) else $error("freewheel amplitude not zero");
   a_scale_follow: assert property ((!standstill && !loadReduceEn && $stable(runCurrent)) [*3]
      |-> actualCurrentScale == runCurrent) else $error("current scale not run value");
   a_interval_cause: assert property ($changed(stepInterval) |-> stepInterval == STEP_MAX
      || $past(stepPulse, 3) || $past(stepPulse, 4)) else $error("interval changed without step");
   a_offset_term: assert property (s_ff_quiet ##1 s_ff_quiet ##1 s_ff_quiet
      |-> totalAmplitude == offTerm[9:0]) else $error("standstill amplitude wrong");
endmodule
bind vpas_scaler vpas_scaler_asserts u_asserts (
   .clock              (clock),
   .rst_n              (rst_n),
   .autoScaleEn        (autoScaleEn),
   .slowDecayMeasureEn (slowDecayMeasureEn),
   .freewheelEn        (freewheelEn),
   .standstill         (standstill),
   .loadReduceEn       (loadReduceEn),
   .stepPulse          (stepPulse),
   .blankTimeSel       (blankTimeSel),
   .amplitudeOffset    (amplitudeOffset),
   .runCurrent         (runCurrent),
   .totalAmplitude     (totalAmplitude),
   .pwmDuty            (pwmDuty),
   .chopOn             (chopOn),
   .measureSample      (measureSample),
   .stepInterval       (stepInterval),
   .actualCurrentScale (actualCurrentScale)
);

//--- tb/vpas_scaler_bench.sv
// ----------------------------------------
// Amplitude scaler bench
// ----------------------------------------
module vpas_scaler_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import vpas_pkg::*;
   logic clock = 0, rst_n = 0, autoScaleEn = 0, slowDecayMeasureEn = 0, freewheelEn = 0;
   logic standstill = 0, loadReduceEn = 0, stepPulse = 0, currentBelowTarget = 0;
   logic [1:0]  blankTimeSel = 2'h1, chopperFreqSel = 2'h0;
   logic [7:0]  amplitudeOffset = 8'h00, amplitudeGradient = 8'h00, tunedOffset, tunedGradient;
   logic [4:0]  runCurrent = 5'h08, holdCurrent = 5'h04, loadReducedCurrent = 5'h02;
   logic [4:0]  actualCurrentScale;
   logic [9:0]  totalAmplitude, pwmDuty, a;
   logic [19:0] stepInterval;
   logic        chopOn, measureSample, ss;
   int          failures = 0, checked = 0, seed = 32'he1935ca1, cyc = 0;
   int          off, grad, rc, hc, cs, n;
   vpas_scaler DUT (
      .clock              (clock),
      .rst_n              (rst_n),
      .autoScaleEn        (autoScaleEn),
      .slowDecayMeasureEn (slowDecayMeasureEn),
      .freewheelEn        (freewheelEn),
      .standstill         (standstill),
      .blankTimeSel       (blankTimeSel),
      .chopperFreqSel     (chopperFreqSel),
      .amplitudeOffset    (amplitudeOffset),
      .amplitudeGradient  (amplitudeGradient),
      .runCurrent         (runCurrent),
      .holdCurrent        (holdCurrent),
      .loadReducedCurrent (loadReducedCurrent),
      .loadReduceEn       (loadReduceEn),
      .stepPulse          (stepPulse),
      .currentBelowTarget (currentBelowTarget),
      .totalAmplitude     (totalAmplitude),
      .pwmDuty            (pwmDuty),
      .chopOn             (chopOn),
      .measureSample      (measureSample),
      .tunedOffset        (tunedOffset),
      .tunedGradient      (tunedGradient),
      .stepInterval       (stepInterval),
      .actualCurrentScale (actualCurrentScale)
   );
   // Clock and hang guard
   initial forever #20 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 50000) begin
         failures++;
         finish_test();
      end
   end
   // Expected feed-forward amplitude
   function automatic logic [9:0] ffAmp(int o, int c, int g, int ivl);
      int v;
      int s;
      v = (ivl == STEP_MAX) ? 0 : g * 256 / ivl;
      if (v > 1023) v = 1023;
      else v = v & 'h3fe;
      s = o * (c + 1) / 32 + v;
      return (s > 1023) ? AMP_MAX : s[9:0];
   endfunction
   task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(int k);
      @(posedge clock) stepPulse <= 1'b1;
      repeat (4) @(posedge clock);
      stepPulse <= 1'b0;
      repeat (k - 5) @(posedge clock);
   endtask
   task automatic finish_test();
      if (failures == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge clock);
      #1;
      cmp(totalAmplitude, AMP_RST);
      cmp(stepInterval, STEP_MAX);
      cmp(tunedOffset, TUNE_RST);
      cmp(tunedGradient, TUNE_RST);
      @(posedge clock) rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         off = $random(seed) & 'hff;
         rc = $random(seed) & 'h1f;
         hc = $random(seed) & 'h1f;
         ss = 1'($random(seed));
         amplitudeOffset <= 8'(off);
         amplitudeGradient <= 8'(off);
         runCurrent <= 5'(rc);
         holdCurrent <= 5'(hc);
         standstill <= ss;
         chopperFreqSel <= 2'(i);
         repeat (40) @(posedge clock);
         #1;
         cs = ss ? hc : rc;
         cmp(actualCurrentScale, cs);
         cmp(totalAmplitude, ffAmp(off, cs, off, STEP_MAX));
         cmp(pwmDuty, ffAmp(off, cs, off, STEP_MAX) * 248 >> 8);
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         n = (i == 0) ? 40 : 100 + ($random(seed) & 'h7ff);
         off = (i == 0) ? 255 : $random(seed) & 'hff;
         grad = (i == 0) ? 255 : $random(seed) & 'hff;
         standstill <= 1'b0;
         chopperFreqSel <= 2'h0;
         amplitudeOffset <= 8'(off);
         amplitudeGradient <= 8'(grad);
         repeat (3) step(n);
         repeat (25) @(posedge clock);
         #1;
         cmp(stepInterval, n);
         cmp(totalAmplitude, ffAmp(off, rc, grad, n));
      end
      @(posedge clock);
      freewheelEn <= 1'b1;
      standstill <= 1'b1;
      holdCurrent <= 5'h00;
      repeat (30) @(posedge clock);
      #1;
      cmp(totalAmplitude, 10'h000);
      a = totalAmplitude;
      @(posedge clock);
      freewheelEn <= 1'b0;
      standstill <= 1'b0;
      autoScaleEn <= 1'b1;
      amplitudeOffset <= 8'hff;
      runCurrent <= 5'h10;
      holdCurrent <= 5'h08;
      currentBelowTarget <= 1'b1;
      slowDecayMeasureEn <= 1'b1;
      repeat (3000) @(posedge clock);
      slowDecayMeasureEn <= 1'b0;
      repeat (3000) @(posedge clock);
      #1;
      cmp(totalAmplitude !== a && totalAmplitude < 10'h010, 1'b1);
      finish_test();
   end
endmodule
